// ### chg_ind_pkg.sv
// Constants for the charge status indicator
package chg_ind_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ        = 250_000_000;
  localparam int unsigned BLINK_HZ      = 1;
  // Half period of the blink, 50 percent duty
  localparam int unsigned HALF_CYCLES   = CLK_HZ / (2 * BLINK_HZ);

  // ==========================================================================
  // Operating modes and charger states
  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_CHARGE,
    MODE_OTG
  } op_mode_t;

  typedef enum logic [1:0] {
    CHG_ACTIVE,
    CHG_DONE,
    CHG_SUSPEND_FAULT
  } chg_state_t;

  // ==========================================================================
  // Reset values
  localparam logic PIN_RELEASED = 1'b1;

endpackage

// ### charge_status_indicator.sv
// Open-drain charge and reverse-power status indicator driver
`timescale 1ns/1ps
module charge_status_indicator #(
  parameter int unsigned HALF_PERIOD = chg_ind_pkg::HALF_CYCLES
) (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rst_b,
  // Configuration bits
  input  wire logic                    charge_indicator_disable,
  input  wire logic                    otg_indicator_enable,
  // Operating status from the charger core
  input  wire chg_ind_pkg::op_mode_t   op_mode,
  input  wire chg_ind_pkg::chg_state_t chg_state,
  input  wire logic                    otg_output_valid,
  input  wire logic                    otg_fault_state,
  input  wire logic                    hiccup_retry_state,
  input  wire logic                    light_load_shutdown_state,
  // Open-drain pin, output and enable (enable low while driving)
  input  wire logic                    charge_status_pin_in,
  output logic                         charge_status_pin_out,
  output logic                         charge_status_pin_oe_b
);

  // ==========================================================================
  // Usage notes
  // The pin is a pull-down only. The pad ties its data to zero and lets the
  // enable decide, so a wiring fault can never drive the pin high against an
  // LED or a host input.
  // The decision is made one clock after the status inputs change. The extra
  // cycle costs nothing at a 1 Hz blink and keeps the pin glitch free.
  // The blink counter only runs while blinking. Each entry into suspend or
  // fault therefore starts with a full low half. A host that times the first
  // edge sees a whole half period, not a stray short pulse.
  // Restarting after a light-load shutdown is the host's job: it must leave
  // OTG mode and enter it again. Until the controller clears its shutdown
  // flag the pin stays released, even in OTG mode with the indicator on.
  // The readback from the pad is only watched by an assertion. It is brought
  // through two flops first because the pad level is not timed to mclk.

  // ==========================================================================
  // Elaboration check
  if (HALF_PERIOD < 2) begin : g_bad_period
    $error("HALF_PERIOD must be at least 2");
  end

  localparam int unsigned CW = $clog2(HALF_PERIOD);

  // ==========================================================================
  // Pin readback synchroniser
  // The pad level settles outside mclk timing, so two flops come first
  logic pin_meta;
  logic pin_sync;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      pin_meta <= chg_ind_pkg::PIN_RELEASED;
      pin_sync <= chg_ind_pkg::PIN_RELEASED;
    end else begin
      pin_meta <= charge_status_pin_in;
      pin_sync <= pin_meta; // Only the second flop is read
    end
  end

  // ==========================================================================
  // Blink time base
  logic [CW-1:0] blink_cnt;
  logic          blink_phase;
  wire           blink_wrap = (blink_cnt == CW'(HALF_PERIOD - 1));
  wire  [CW-1:0] next_blink_cnt = blink_wrap ? '0 : blink_cnt + CW'(1);

  // Counter only runs while blinking so each blink starts with a full low half
  wire chg_on  = (op_mode == chg_ind_pkg::MODE_CHARGE) && !charge_indicator_disable;
  wire otg_on  = (op_mode == chg_ind_pkg::MODE_OTG) && otg_indicator_enable;
  wire blinking = chg_on && (chg_state == chg_ind_pkg::CHG_SUSPEND_FAULT);

  always_ff @(posedge mclk) begin
    if (!rst_b || !blinking) begin
      blink_cnt   <= '0;
      blink_phase <= 1'b0;
    end else begin
      blink_cnt <= next_blink_cnt;
      if (blink_wrap) begin
        blink_phase <= ~blink_phase;
      end
    end
  end

  // ==========================================================================
  // Pin decision: pull low or release
  wire otg_bad  = otg_fault_state || hiccup_retry_state || light_load_shutdown_state;
  wire chg_low  = chg_on && ((chg_state == chg_ind_pkg::CHG_ACTIVE) ||
                             (blinking && !blink_phase));
  wire otg_low  = otg_on && otg_output_valid && !otg_bad;
  wire next_pull = chg_low || otg_low;

  // Output data is a constant zero; only the enable toggles, never high
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      charge_status_pin_oe_b <= chg_ind_pkg::PIN_RELEASED;
      charge_status_pin_out  <= 1'b0;
    end else begin
      charge_status_pin_oe_b <= ~next_pull;
      charge_status_pin_out  <= 1'b0;
    end
  end

  // ==========================================================================
  // Assertions
  never_high_a: assert property (@(posedge mclk) disable iff (!rst_b)
    charge_status_pin_out == 1'b0) else $error("pin output driven high");

  chg_disable_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (op_mode == chg_ind_pkg::MODE_CHARGE && charge_indicator_disable)
      |=> charge_status_pin_oe_b) else $error("charge indicator not off");

  otg_disable_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (op_mode == chg_ind_pkg::MODE_OTG && !otg_indicator_enable)
      |=> charge_status_pin_oe_b) else $error("otg indicator not off");

  chg_active_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (chg_on && chg_state == chg_ind_pkg::CHG_ACTIVE) |=> !charge_status_pin_oe_b)
    else $error("charging but pin released");

  chg_done_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (chg_on && chg_state == chg_ind_pkg::CHG_DONE) |=> charge_status_pin_oe_b)
    else $error("charge done but pin low");

  blink_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
    ($rose(blinking) ##1 blinking) |-> !charge_status_pin_oe_b)
    else $error("blink does not start low");

  blink_flip_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (blinking && blink_wrap) ##1 blinking |=> $changed(charge_status_pin_oe_b))
    else $error("blink did not toggle at half period");

  otg_valid_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (otg_on && otg_output_valid && !otg_bad) |=> !charge_status_pin_oe_b)
    else $error("otg valid but pin released");

  otg_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (op_mode != chg_ind_pkg::MODE_OTG && !chg_on) |=> charge_status_pin_oe_b)
    else $error("otg off but pin low");

  otg_bad_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (otg_on && otg_bad) |=> charge_status_pin_oe_b)
    else $error("otg fault but pin low");

  // Reset leaves the pin released with its data at zero
  reset_release_a: assert property (@(posedge mclk)
    !rst_b |=> (charge_status_pin_oe_b && !charge_status_pin_out))
    else $error("pin not released after reset");

  // Idle mode has no indicator function at all
  idle_release_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (op_mode == chg_ind_pkg::MODE_IDLE) |=> charge_status_pin_oe_b)
    else $error("idle mode but pin low");

  // Checked from the raw inputs so a broken decode of chg_on shows up
  chg_enable_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (op_mode == chg_ind_pkg::MODE_CHARGE && !charge_indicator_disable &&
     chg_state == chg_ind_pkg::CHG_ACTIVE) |=> !charge_status_pin_oe_b)
    else $error("charge indicator enabled but pin released");

  // Checked from the raw inputs so a broken decode of otg_bad shows up
  otg_enable_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (op_mode == chg_ind_pkg::MODE_OTG && otg_indicator_enable && otg_output_valid &&
     !otg_fault_state && !hiccup_retry_state && !light_load_shutdown_state)
      |=> !charge_status_pin_oe_b)
    else $error("otg indicator enabled but pin released");

  // Light-load shutdown alone must keep the pin released
  otg_ll_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (op_mode == chg_ind_pkg::MODE_OTG && light_load_shutdown_state)
      |=> charge_status_pin_oe_b)
    else $error("light-load shutdown but pin low");

  // Between wraps the blink level must not move
  blink_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (blinking && !blink_wrap) ##1 blinking |=> $stable(charge_status_pin_oe_b))
    else $error("blink level moved inside a half period");

  // A pulled pin must read back low once through the synchroniser
  readback_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !charge_status_pin_oe_b |-> ##2 !pin_sync)
    else $error("pin pulled low but reads back high");

  // Main scenarios
  cov_chg_off: cover property (@(posedge mclk) disable iff (!rst_b)
    op_mode == chg_ind_pkg::MODE_CHARGE && charge_indicator_disable);
  cov_charging: cover property (@(posedge mclk) disable iff (!rst_b)
    chg_on && chg_state == chg_ind_pkg::CHG_ACTIVE ##1 !charge_status_pin_oe_b);
  cov_blink: cover property (@(posedge mclk) disable iff (!rst_b)
    blinking && blink_wrap && !blink_phase);
  cov_otg_valid: cover property (@(posedge mclk) disable iff (!rst_b) otg_low);
  cov_otg_ll: cover property (@(posedge mclk) disable iff (!rst_b)
    otg_on && light_load_shutdown_state);

endmodule // charge_status_indicator

// ### led_pin_model.sv
// Pulled-up indicator load that resolves the open-drain status wire
`timescale 1ns/1ps
// ============================================================
// Load model
module led_pin_model (
  // Pin halves from the device
  input  wire logic pin_out,
  input  wire logic pin_oe_b,
  // Resolved wire level
  output logic      pin_level
);
  // Released pin floats up through the pull-up; a driven high shows as unknown
  assign pin_level = pin_oe_b ? 1'b1 : (pin_out ? 1'bx : 1'b0);
endmodule // led_pin_model

// ### testbench.sv
// Random and corner-case bench for the charge status indicator
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
// ============================================================
// Bench
module testbench;
  localparam int unsigned H = 4;
  logic                    mclk = 1'b0, rst_b = 1'b0, dis = 1'b0, en = 1'b0;
  logic                    vld = 1'b0, flt = 1'b0, hic = 1'b0, ll = 1'b0;
  chg_ind_pkg::op_mode_t   mode = chg_ind_pkg::MODE_IDLE;
  chg_ind_pkg::chg_state_t st = chg_ind_pkg::CHG_ACTIVE;
  logic                    pin_out, pin_oe_b, pin_level, exp_oe_b = 1'b1;
  int                      n_errors = 0, tests_run = 0, seed = 94023, ph = 0, r;
  always #2 mclk = ~mclk;
  charge_status_indicator #(.HALF_PERIOD(H)) DUT (.mclk(mclk), .rst_b(rst_b),
    .charge_indicator_disable(dis), .otg_indicator_enable(en), .op_mode(mode),
    .chg_state(st), .otg_output_valid(vld), .otg_fault_state(flt),
    .hiccup_retry_state(hic), .light_load_shutdown_state(ll),
    .charge_status_pin_in(pin_level), .charge_status_pin_out(pin_out),
    .charge_status_pin_oe_b(pin_oe_b));
  led_pin_model load (.pin_out(pin_out), .pin_oe_b(pin_oe_b), .pin_level(pin_level));
  // Expected enable when not blinking; idle or disabled modes stay released
  function automatic logic steady();
    if (mode == chg_ind_pkg::MODE_CHARGE && !dis) return st != chg_ind_pkg::CHG_ACTIVE;
    if (mode == chg_ind_pkg::MODE_OTG && en) return !(vld && !flt && !hic && !ll);
    return 1'b1;
  endfunction
  // Reference: one-cycle latency, blink phase restarts on every entry
  always @(posedge mclk) begin
    if (!rst_b) begin
      exp_oe_b <= 1'b1;
      ph <= 0;
    end else if (mode == chg_ind_pkg::MODE_CHARGE && !dis && st == chg_ind_pkg::CHG_SUSPEND_FAULT) begin
      exp_oe_b <= (ph >= H);
      ph <= (ph + 1) % (2 * H);
    end else begin
      exp_oe_b <= steady();
      ph <= 0;
    end
  end
  // Outputs are settled by the falling edge
  always @(negedge mclk) begin
    `CHK(pin_oe_b, exp_oe_b)
    `CHK(pin_level, exp_oe_b)
  end
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic final_report;
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    step(3);
    rst_b <= 1'b1;
    // Long blink, then disable in mid-blink and re-enter
    mode <= chg_ind_pkg::MODE_CHARGE;
    st <= chg_ind_pkg::CHG_SUSPEND_FAULT;
    step(3 * H + 1);
    dis <= 1'b1;
    step(2);
    dis <= 1'b0;
    step(H + 1);
    // Valid OTG, then light-load shutdown left by host re-entry
    mode <= chg_ind_pkg::MODE_OTG;
    en <= 1'b1;
    vld <= 1'b1;
    step(2);
    ll <= 1'b1;
    step(2);
    mode <= chg_ind_pkg::MODE_IDLE;
    ll <= 1'b0;
    step(2);
    mode <= chg_ind_pkg::MODE_OTG;
    step(2);
    // Random traffic with occasional resets in mid-run
    repeat (4000) begin
      r = $random(seed);
      if (r[2:0] == 3'h0) begin
        mode <= chg_ind_pkg::op_mode_t'(2'($unsigned(r[15:8]) % 3));
        st <= chg_ind_pkg::chg_state_t'(2'($unsigned(r[23:16]) % 3));
        {dis, en, vld, flt, hic, ll} <= r[29:24];
      end
      rst_b <= (r[31:20] != 12'h000);
      step(1);
    end
    final_report();
  end
endmodule // testbench
